// ---- rtl/ctv_regs.vh ----
// register offsets, field positions, reset values and timing constants
`ifndef CTV_REGS_VH
`define CTV_REGS_VH

// register indices as printed; byte address is four times the index
`define CTV_IDX_CLK_CFG 10'h018
`define CTV_IDX_OUT_SET 10'h05b
`define CTV_IDX_LUT_SEL 10'h1e0
`define CTV_IDX_DISP_MODE 10'h1fc
`define CTV_IDX_STATUS 10'h200
`define CTV_IDX_LUT_ADDR 10'h201
`define CTV_IDX_LUT_DATA 10'h202
`define CTV_IDX_TV_RES 10'h203

// field positions
`define CTV_CLK_DOUBLER_BIT 7
`define CTV_SET_CHROMA_BIT 5
`define CTV_SET_LUMA_BIT 4
`define CTV_SET_DAC_LVL_BIT 3
`define CTV_SET_STD_BIT 0
`define CTV_LUT_SEPARATE_BIT 0
`define CTV_LUT_TARGET_BIT 1

// reset values
`define CTV_RST_CLK_CFG 8'h00
`define CTV_RST_OUT_SET 8'h00
`define CTV_RST_LUT_SEL 8'h00
`define CTV_RST_DISP_MODE 8'h00
`define CTV_RST_TV_RES 8'h00

// display mode field encodings
`define CTV_MODE_OFF 3'h0
`define CTV_MODE_CRT 3'h1
`define CTV_MODE_TV_CVBS 3'h2
`define CTV_MODE_TV_SVID 3'h3
`define CTV_MODE_TV_CVBS_FF 3'h6
`define CTV_MODE_TV_SVID_FF 3'h7

// tv reference clocks in kHz
`define CTV_NTSC_REF_KHZ 15'h37ee
`define CTV_PAL_REF_KHZ 15'h4546

// axi responses
`define CTV_RESP_OKAY 2'h0
`define CTV_RESP_SLVERR 2'h2

`endif

// ---- rtl/ctv_output_ctrl.v ----
// crt/tv output selection and picture quality control, axi4-lite slave
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ns
// What this block does
// R1 - lcd runs with crt or tv, never crt and tv together
// R2 - mode field bits 2-0 picks secondary output and flicker filter
// R3 - writing 1 enables crt when crt and tv were both off before
// R4 - writing 06h enables tv with flicker filter on
// R5 - software sets pixel clock doubler bit 7 whenever flicker filter on
// R6 - settings bit 5 enables tv chrominance filter
// R7 - settings bit 4 enables tv luminance filter
// R8 - flicker, chrominance and luminance filters are independent
// R9 - settings bit 3 doubles dac values while crt is active
// R10 - software clears tv standard select bit 0 before enabling crt
// R11 - software clears mode bits 2-1 before enabling crt
// R12 - lookup select bit 0 low writes both lcd and crt/tv tables
// R13 - lcd and crt/tv paths use their own table and layers
// R14 - ntsc timing from 14.318 mhz at 640x480, 696x436, 752x484
// R15 - pal timing from 17.734 mhz at four listed resolutions
// R16 - tv picture delivered as composite or s-video
// R17 - undescribed mode encodings are reserved and keep crt/tv off
`include "ctv_regs.vh"

module ctv_output_ctrl #(
   parameter LUT_DEPTH = 256,
   parameter LUT_AW = 8,
   parameter LUT_DW = 8
) (
   input wire aclk,
   input wire aresetn,
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [LUT_AW-1:0] lcd_pix_index,
   input wire [LUT_AW-1:0] crt_pix_index,
   output reg [LUT_DW-1:0] lcd_lut_data,
   output reg [LUT_DW:0] dac_code,
   output reg crt_active,
   output reg tv_active,
   output reg tv_svideo,
   output reg flicker_filter_en,
   output reg chroma_filter_en,
   output reg luma_filter_en,
   output reg dac_double,
   output reg tv_standard_select,
   output reg pixel_clock_doubler,
   output reg [9:0] tv_h_active,
   output reg [9:0] tv_v_active,
   output reg [14:0] tv_ref_clk_khz,
   output reg tv_res_valid
);

   // ************************************************************
   // registers and tables
   // ************************************************************
   reg [7:0] clk_cfg_q;
   reg [7:0] out_set_q;
   reg [7:0] lut_sel_q;
   reg [7:0] mode_q;
   reg [7:0] tv_res_q;
   reg [LUT_AW-1:0] lut_addr_q;
   reg [LUT_DW-1:0] lcd_lut [0:LUT_DEPTH-1];
   reg [LUT_DW-1:0] crt_lut [0:LUT_DEPTH-1];
   // break-before-make: set when crt was requested while tv was live
   reg crt_blocked_q;

   // ************************************************************
   // axi write channel
   // ************************************************************
   reg aw_held_q;
   reg w_held_q;
   reg [9:0] aw_idx_q;
   reg [31:0] wdata_q;
   reg wstrb0_q;
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire [9:0] wr_idx = aw_take ? s_axi_awaddr[11:2] : aw_idx_q;
   wire [31:0] wr_data = w_take ? s_axi_wdata : wdata_q;
   wire wr_lane0 = w_take ? s_axi_wstrb[0] : wstrb0_q;
   wire wr_go = (aw_take | aw_held_q) & (w_take | w_held_q) &
      ~s_axi_bvalid;
   reg wr_hit;
   always @* begin
      case (wr_idx)
         `CTV_IDX_CLK_CFG, `CTV_IDX_OUT_SET, `CTV_IDX_LUT_SEL,
         `CTV_IDX_DISP_MODE, `CTV_IDX_LUT_ADDR, `CTV_IDX_LUT_DATA,
         `CTV_IDX_TV_RES: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end
   wire wr_en = wr_go & wr_hit & wr_lane0;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CTV_RESP_OKAY;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_idx_q <= 10'h000;
         wdata_q <= 32'h0000_0000;
         wstrb0_q <= 1'b0;
      end else begin
         if (aw_take) begin
            aw_idx_q <= s_axi_awaddr[11:2];
         end
         if (w_take) begin
            wdata_q <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `CTV_RESP_OKAY : `CTV_RESP_SLVERR;
         end else begin
            aw_held_q <= aw_held_q | aw_take;
            w_held_q <= w_held_q | w_take;
            if (s_axi_bvalid && s_axi_bready) begin
               s_axi_bvalid <= 1'b0;
            end
         end
         // one write at a time: ready drops once a channel is held
         s_axi_awready <= ~(aw_held_q | aw_take) | wr_go;
         s_axi_wready <= ~(w_held_q | w_take) | wr_go;
         if (s_axi_awready && !aw_take && aw_held_q) begin
            s_axi_awready <= 1'b0;
         end
      end
   end

   // ************************************************************
   // register writes
   // ************************************************************
   wire [2:0] new_mode = wr_data[2:0];
   wire tv_live = (mode_q[2:0] == `CTV_MODE_TV_CVBS) |
      (mode_q[2:0] == `CTV_MODE_TV_SVID) |
      (mode_q[2:0] == `CTV_MODE_TV_CVBS_FF) |
      (mode_q[2:0] == `CTV_MODE_TV_SVID_FF);

   always @(posedge aclk) begin
      if (!aresetn) begin
         clk_cfg_q <= `CTV_RST_CLK_CFG;
         out_set_q <= `CTV_RST_OUT_SET;
         lut_sel_q <= `CTV_RST_LUT_SEL;
         mode_q <= `CTV_RST_DISP_MODE;
         tv_res_q <= `CTV_RST_TV_RES;
         lut_addr_q <= {LUT_AW{1'b0}};
         crt_blocked_q <= 1'b0;
      end else if (wr_en) begin
         case (wr_idx)
            `CTV_IDX_CLK_CFG: clk_cfg_q <= wr_data[7:0];
            `CTV_IDX_OUT_SET: out_set_q <= wr_data[7:0];
            `CTV_IDX_LUT_SEL: lut_sel_q <= wr_data[7:0];
            `CTV_IDX_TV_RES: tv_res_q <= wr_data[7:0];
            `CTV_IDX_LUT_ADDR: lut_addr_q <= wr_data[LUT_AW-1:0];
            `CTV_IDX_DISP_MODE: begin
               mode_q <= wr_data[7:0];
               // crt only comes up from a state with crt and tv off
               crt_blocked_q <= (new_mode == `CTV_MODE_CRT) &
                  tv_live; // R3
            end
            // index steps so a palette loads with back-to-back writes
            `CTV_IDX_LUT_DATA: lut_addr_q <= lut_addr_q + 1'b1;
            default: lut_addr_q <= lut_addr_q;
         endcase
      end
   end

   // table writes; no reset on the arrays, software loads them
   wire lut_wr = wr_en & (wr_idx == `CTV_IDX_LUT_DATA);
   wire lut_both = ~lut_sel_q[`CTV_LUT_SEPARATE_BIT];
   wire lut_to_crt = lut_sel_q[`CTV_LUT_TARGET_BIT];
   always @(posedge aclk) begin
      if (lut_wr && (lut_both || !lut_to_crt)) begin
         lcd_lut[lut_addr_q] <= wr_data[LUT_DW-1:0]; // R12
      end
      if (lut_wr && (lut_both || lut_to_crt)) begin
         crt_lut[lut_addr_q] <= wr_data[LUT_DW-1:0]; // R12
      end
   end

   // ************************************************************
   // mode decode and outputs
   // ************************************************************
   reg crt_d;
   reg tv_d;
   reg svid_d;
   reg ff_d;
   always @* begin
      crt_d = 1'b0;
      tv_d = 1'b0;
      svid_d = 1'b0;
      ff_d = 1'b0;
      case (mode_q[2:0]) // R2
         `CTV_MODE_CRT: crt_d = ~crt_blocked_q; // R3
         `CTV_MODE_TV_CVBS: tv_d = 1'b1; // R16
         `CTV_MODE_TV_SVID: begin
            tv_d = 1'b1;
            svid_d = 1'b1; // R16
         end
         `CTV_MODE_TV_CVBS_FF: begin
            tv_d = 1'b1;
            ff_d = 1'b1; // R4
         end
         `CTV_MODE_TV_SVID_FF: begin
            tv_d = 1'b1;
            svid_d = 1'b1;
            ff_d = 1'b1;
         end
         default: begin
            crt_d = 1'b0; // R17
            tv_d = 1'b0;
         end
      endcase
   end

   // filters, s-video and doubling follow the gated enables, so none of
   // them shows during the dead cycle of a direct crt/tv switch
   wire crt_go = crt_d & ~tv_active; // R1
   wire tv_go = tv_d & ~crt_active; // R1

   // resolution table per tv standard
   reg [9:0] h_d;
   reg [9:0] v_d;
   reg res_ok_d;
   wire pal = out_set_q[`CTV_SET_STD_BIT];
   always @* begin
      res_ok_d = 1'b1;
      h_d = 10'h280;
      v_d = 10'h1e0;
      case ({pal, tv_res_q[1:0]})
         3'h0: h_d = 10'h280; // R14
         3'h1: begin
            h_d = 10'h2b8;
            v_d = 10'h1b4; // R14
         end
         3'h2: begin
            h_d = 10'h2f0;
            v_d = 10'h1e4; // R14
         end
         3'h4: h_d = 10'h280; // R15
         3'h5: begin
            h_d = 10'h320;
            v_d = 10'h23c; // R15
         end
         3'h6: begin
            h_d = 10'h358;
            v_d = 10'h206; // R15
         end
         3'h7: begin
            h_d = 10'h398;
            v_d = 10'h23c; // R15
         end
         default: res_ok_d = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         crt_active <= 1'b0;
         tv_active <= 1'b0;
         tv_svideo <= 1'b0;
         flicker_filter_en <= 1'b0;
         chroma_filter_en <= 1'b0;
         luma_filter_en <= 1'b0;
         dac_double <= 1'b0;
         tv_standard_select <= 1'b0;
         pixel_clock_doubler <= 1'b0;
         tv_h_active <= 10'h000;
         tv_v_active <= 10'h000;
         tv_ref_clk_khz <= 15'h0000;
         tv_res_valid <= 1'b0;
         lcd_lut_data <= {LUT_DW{1'b0}};
         dac_code <= {(LUT_DW+1){1'b0}};
      end else begin
         // a switch between crt and tv passes through both off
         crt_active <= crt_go; // R1
         tv_active <= tv_go; // R1
         tv_svideo <= svid_d & tv_go; // R16
         flicker_filter_en <= ff_d & tv_go; // R8
         chroma_filter_en <= tv_go & out_set_q[`CTV_SET_CHROMA_BIT]; // R6 R8
         luma_filter_en <= tv_go & out_set_q[`CTV_SET_LUMA_BIT]; // R7 R8
         dac_double <= crt_go & out_set_q[`CTV_SET_DAC_LVL_BIT]; // R9
         tv_standard_select <= pal;
         // doubler is only what software set; it must match the filter
         pixel_clock_doubler <= clk_cfg_q[`CTV_CLK_DOUBLER_BIT]; // R5
         tv_h_active <= h_d;
         tv_v_active <= v_d;
         tv_ref_clk_khz <= pal ? `CTV_PAL_REF_KHZ : `CTV_NTSC_REF_KHZ;
         tv_res_valid <= res_ok_d; // R14 R15
         lcd_lut_data <= lcd_lut[lcd_pix_index]; // R13
         if (dac_double) begin
            dac_code <= {crt_lut[crt_pix_index], 1'b0}; // R9 R13
         end else begin
            dac_code <= {1'b0, crt_lut[crt_pix_index]}; // R13
         end
      end
   end

   // ************************************************************
   // axi read channel
   // ************************************************************
   reg [31:0] rd_d;
   reg rd_hit;
   wire [9:0] rd_idx = s_axi_araddr[11:2];
   always @* begin
      rd_d = 32'h0000_0000;
      rd_hit = 1'b1;
      case (rd_idx)
         `CTV_IDX_CLK_CFG: rd_d[7:0] = clk_cfg_q;
         `CTV_IDX_OUT_SET: rd_d[7:0] = out_set_q;
         `CTV_IDX_LUT_SEL: rd_d[7:0] = lut_sel_q;
         `CTV_IDX_DISP_MODE: rd_d[7:0] = mode_q;
         `CTV_IDX_TV_RES: rd_d[7:0] = tv_res_q;
         `CTV_IDX_LUT_ADDR: rd_d[LUT_AW-1:0] = lut_addr_q;
         `CTV_IDX_LUT_DATA: rd_d[LUT_DW-1:0] = lut_to_crt ?
            crt_lut[lut_addr_q] : lcd_lut[lut_addr_q];
         `CTV_IDX_STATUS: rd_d[5:0] = {tv_res_valid, dac_double,
            flicker_filter_en, tv_svideo, tv_active, crt_active};
         default: rd_hit = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `CTV_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_d;
            s_axi_rresp <= rd_hit ? `CTV_RESP_OKAY : `CTV_RESP_SLVERR;
         end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
               s_axi_rvalid <= 1'b0;
            end
         end else begin
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

// ---- sim/ctv_monitor.sv ----
// behavioural crt screen on the far side of the output block; tv only drives the clash flag
`timescale 1ns/1ns
module ctv_monitor (
   input wire aclk,
   input wire crt_active,
   input wire tv_active,
   input wire [8:0] dac_code,
   input wire [7:0] beam,
   output logic [7:0] crt_pix_index,
   output logic [8:0] shown,
   output logic clash
);
   initial clash = 1'h0;
   always @(posedge aclk) begin
      // the screen asks for the pixel under its beam
      crt_pix_index <= beam;
      // a dark screen shows black, never a stale pixel
      shown <= crt_active ? dac_code : 9'h000;
      if (crt_active && tv_active)
         clash <= 1'h1;
   end
endmodule

// ---- sim/ctv_output_sva.sv ----
// concurrent checks on the crt/tv output control ports
`timescale 1ns/1ns
module ctv_output_sva (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire crt_active,
   input wire tv_active,
   input wire tv_svideo,
   input wire flicker_filter_en,
   input wire chroma_filter_en,
   input wire luma_filter_en,
   input wire dac_double
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   excl_out_a:
   assert property (!(crt_active && tv_active))
      else $error("crt and tv active together");
   switch_gap_a:
   assert property ($rose(crt_active) |-> !$past(tv_active))
      else $error("crt rose while tv was live");
   flick_tv_a:
   assert property (flicker_filter_en |-> tv_active)
      else $error("flicker filter without tv");
   chroma_tv_a:
   assert property (chroma_filter_en |-> tv_active)
      else $error("chroma filter without tv");
   luma_tv_a:
   assert property (luma_filter_en |-> tv_active)
      else $error("luma filter without tv");
   dac_crt_a:
   assert property (dac_double |-> crt_active)
      else $error("dac doubling without crt");
   svid_tv_a:
   assert property (tv_svideo |-> tv_active)
      else $error("s-video without tv");
   wr_answer_a:
   assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready && !s_axi_bvalid
      |=> s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write not answered next cycle");
   rd_answer_a:
   assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered next cycle");
endmodule
bind ctv_output_ctrl ctv_output_sva u_sva (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .crt_active, .tv_active, .tv_svideo, .flicker_filter_en,
   .chroma_filter_en, .luma_filter_en, .dac_double);

// ---- sim/testbench.sv ----
// self-checking bench for the crt/tv output control block
`timescale 1ns/1ns
`include "ctv_regs.vh"
module testbench;
   localparam logic [9:0] CK = `CTV_IDX_CLK_CFG;
   localparam logic [9:0] ST = `CTV_IDX_OUT_SET;
   localparam logic [9:0] LS = `CTV_IDX_LUT_SEL;
   localparam logic [9:0] MD = `CTV_IDX_DISP_MODE;
   localparam logic [9:0] LA = `CTV_IDX_LUT_ADDR;
   localparam logic [9:0] LD = `CTV_IDX_LUT_DATA;
   localparam logic [1:0] OK = `CTV_RESP_OKAY;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [7:0] lcd_pix_index = 8'h00, beam = 8'h00;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, crt_active, tv_active, tv_svideo, flicker_filter_en;
   wire chroma_filter_en, luma_filter_en, dac_double, tv_standard_select;
   wire pixel_clock_doubler, tv_res_valid, clash;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [7:0] crt_pix_index, lcd_lut_data;
   wire [8:0] dac_code, shown;
   wire [9:0] tv_h_active, tv_v_active;
   wire [14:0] tv_ref_clk_khz;
   int failures = 0;
   int n_checks = 0;
   ctv_output_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lcd_pix_index,
      .crt_pix_index, .lcd_lut_data, .dac_code, .crt_active, .tv_active,
      .tv_svideo, .flicker_filter_en, .chroma_filter_en, .luma_filter_en,
      .dac_double, .tv_standard_select, .pixel_clock_doubler,
      .tv_h_active, .tv_v_active, .tv_ref_clk_khz, .tv_res_valid);
   ctv_monitor mon (.aclk, .crt_active, .tv_active, .dac_code, .beam,
      .crt_pix_index, .shown, .clash);
   // ****************************************
   // bus and compare helpers
   // ****************************************
   task automatic chk(input [31:0] got, input [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic nap(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask
   // entry edge keeps a release and a new request apart
   task automatic wr(input [9:0] i, input [7:0] d, output [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= {i, 2'h0};
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task automatic rc(input [9:0] i, input [31:0] e, input [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= {i, 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, er);
      s_axi_rready <= 1'h0;
   endtask
   task automatic wo(input [9:0] i, input [7:0] d);
      logic [1:0] r;
      wr(i, d, r);
      chk(r, OK);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs;
      logic [1:0] r;
      rc(CK, 32'h0000_0000, OK);
      rc(ST, 32'h0000_0000, OK);
      rc(LS, 32'h0000_0000, OK);
      rc(MD, 32'h0000_0000, OK);
      rc(10'h3ff, 32'h0000_0000, `CTV_RESP_SLVERR);
      wr(10'h3ff, 8'h5a, r);
      chk(r, `CTV_RESP_SLVERR);
      s_axi_wstrb <= 4'h0;
      wo(CK, 8'hff);
      s_axi_wstrb <= 4'hf;
      rc(CK, 32'h0000_0000, OK);
      wo(CK, 8'h80);
      rc(CK, 32'h0000_0080, OK);
      chk(pixel_clock_doubler, 1'h1);
      $display("t_regs done");
   endtask
   task automatic t_crt;
      wo(ST, 8'h00);
      wo(MD, 8'h00);
      wo(MD, 8'h01);
      nap(1);
      chk(crt_active, 1'h1);
      rc(`CTV_IDX_STATUS, 32'h0000_0021, OK);
      wo(ST, 8'h08);
      wo(LS, 8'h00);
      wo(LA, 8'h05);
      wo(LD, 8'h41);
      wo(LS, 8'h01);
      wo(LA, 8'h05);
      wo(LD, 8'h22);
      lcd_pix_index <= 8'h05;
      beam <= 8'h05;
      nap(4);
      chk(lcd_lut_data, 8'h22);
      chk(shown, 9'h082);
      wo(ST, 8'h00);
      nap(4);
      chk(shown, 9'h041);
      wo(LS, 8'h03);
      wo(LA, 8'h05);
      wo(LD, 8'h33);
      wo(LA, 8'h05);
      rc(LD, 32'h0000_0033, OK);
      nap(4);
      chk(shown, 9'h033);
      chk(lcd_lut_data, 8'h22);
      $display("t_crt done");
   endtask
   task automatic t_modes;
      logic [2:0] m;
      for (int k = 0; k < 8; k++) begin
         m = k[2:0];
         wo(MD, 8'h00);
         wo(MD, {5'h00, m});
         nap(1);
         chk(crt_active, m == 3'h1);
         chk(tv_active, m inside {3'h2, 3'h3, 3'h6, 3'h7});
         chk(tv_svideo, m[0] && m[1]);
         chk(flicker_filter_en, m[2] && m[1]);
      end
      wo(MD, 8'h06);
      for (int f = 0; f < 4; f++) begin
         wo(ST, {2'h0, f[1:0], 4'h0});
         nap(1);
         chk(chroma_filter_en, f[1]);
         chk(luma_filter_en, f[0]);
         chk(flicker_filter_en, 1'h1);
      end
      wo(MD, 8'h01);
      nap(1);
      chk({crt_active, tv_active}, 2'h0);
      wo(MD, 8'h00);
      wo(MD, 8'h01);
      wo(MD, 8'h06);
      nap(0);
      chk({crt_active, tv_active, flicker_filter_en}, 3'h0);
      nap(1);
      chk({crt_active, tv_active, flicker_filter_en}, 3'h3);
      $display("t_modes done");
   endtask
   task automatic t_res;
      logic [9:0] hx [8] = '{10'h280, 10'h2b8, 10'h2f0, 10'h000,
         10'h280, 10'h320, 10'h358, 10'h398};
      logic [9:0] vx [8] = '{10'h1e0, 10'h1b4, 10'h1e4, 10'h000,
         10'h1e0, 10'h23c, 10'h206, 10'h23c};
      wo(MD, 8'h02);
      for (int k = 0; k < 8; k++) begin
         wo(ST, {7'h00, k[2]});
         wo(`CTV_IDX_TV_RES, {6'h00, k[1:0]});
         nap(1);
         chk(tv_standard_select, k[2]);
         chk(tv_res_valid, k != 3);
         if (k != 3) begin
            chk(tv_h_active, hx[k]);
            chk(tv_v_active, vx[k]);
            chk(tv_ref_clk_khz, k[2] ? 15'h4546 : 15'h37ee);
         end
      end
      $display("t_res done");
   endtask
   task automatic final_report;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      forever #50 aclk = ~aclk;
   end
   // the whole run is under three hundred cycles
   initial begin
      #1_000_000;
      failures++;
      final_report;
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      t_regs;
      t_crt;
      t_modes;
      t_res;
      chk(clash, 1'h0);
      final_report;
   end
endmodule
